// ==== verilog/hot_reset_defines.svh ====
// Timing counts, field codes and reset values for the reset control block
`ifndef HOT_RESET_DEFINES_SVH
`define HOT_RESET_DEFINES_SVH

// Reset output pulse: least width and the core clock period, both in ns
`define RST_PULSE_NS 250
`define CORE_CLK_PERIOD_NS 10
// Least time rounds up to whole cycles
`define RST_PULSE_CYCLES ((`RST_PULSE_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)
// Hot-reset message time on a downstream link before the local reset, in cycles
`define HOT_MSG_CYCLES 16
// Far side mode codes
`define FAR_MODE_READY 2'h0
`define FAR_MODE_NOT_READY 2'h1
// Reset action codes
`define ACTION_NONE 2'h0
`define ACTION_INT_NOT_READY 2'h1
`define ACTION_EXT_NOT_READY 2'h2
// Reset output select: external reset
`define ROS_EXT_RESET 2'h1

`endif

// ==== verilog/hot_reset_pkg.sv ====
// Types shared by the reset control block
package hot_reset_pkg;
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_MSG = 2'b01,
		SEQ_RESET = 2'b10
	} seq_state_e;
endpackage

// ==== verilog/reset_pulse_gen.sv ====
// Fixed-width active-low reset pulse timed on the core clock
`include "hot_reset_defines.svh"
module reset_pulse_gen #(
	parameter int unsigned CYCLES = `RST_PULSE_CYCLES
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic reset_in,
	// Trigger and pulse
	input wire logic fire_in,
	output logic pulse_n_out
);
	localparam int unsigned CW = $clog2(CYCLES + 1);
	logic [CW-1:0] count_r;
	logic [CW-1:0] count_nxt;
	logic pulse_n_r;
	logic pulse_n_nxt;

	// A new trigger restarts the full width, so the pulse never comes out short
	always_comb begin
		count_nxt = count_r;
		if (fire_in) begin
			count_nxt = CW'(CYCLES);
		end else if (count_r != '0) begin
			count_nxt = count_r - CW'(1);
		end
		pulse_n_nxt = (count_nxt == '0);
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			count_r <= '0;
			pulse_n_r <= 1'b1;
		end else begin
			count_r <= count_nxt;
			pulse_n_r <= pulse_n_nxt;
		end
	end

	assign pulse_n_out = pulse_n_r;

	a_pulse_width: assert property (@(posedge core_clk_in) disable iff (reset_in)
		$fell(pulse_n_r) |-> !pulse_n_r [*8])
		else $error("reset pulse too short");
endmodule // reset_pulse_gen

// ==== verilog/downstream_hot_seq.sv ====
// Downstream port hot reset sequence: message first, then local reset
`include "hot_reset_defines.svh"
module downstream_hot_seq
	import hot_reset_pkg::*;
#(
	parameter int unsigned MSG_CYCLES = `HOT_MSG_CYCLES
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic reset_in,
	// Request and outputs
	input wire logic start_in,
	output logic send_msg_out,
	output logic port_reset_out
);
	localparam int unsigned CW = $clog2(MSG_CYCLES + 1);
	seq_state_e state_r;
	seq_state_e state_nxt;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;

	// Message phase runs to its end before the port is reset
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		unique case (state_r)
			SEQ_IDLE: begin
				if (start_in) begin
					state_nxt = SEQ_MSG;
					cnt_nxt = CW'(MSG_CYCLES);
				end
			end
			SEQ_MSG: begin
				cnt_nxt = cnt_r - CW'(1);
				if (cnt_r == CW'(1)) begin
					state_nxt = SEQ_RESET;
				end
			end
			SEQ_RESET: begin
				state_nxt = SEQ_IDLE;
			end
			default: begin
				state_nxt = SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_r <= SEQ_IDLE;
			cnt_r <= '0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign send_msg_out = (state_r == SEQ_MSG);
	assign port_reset_out = (state_r == SEQ_RESET);

	a_msg_first: assert property (@(posedge core_clk_in) disable iff (reset_in)
		port_reset_out |-> $past(send_msg_out))
		else $error("port reset without message");
endmodule // downstream_hot_seq

// ==== verilog/hot_reset_ctrl.sv ====
// Hot and bridge-side reset control for a three-port switch
`include "hot_reset_defines.svh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Upstream hot-reset sets or link down reset device
// - Downstream hot-reset sets are ignored
// - Global reset spares PLL, SerDes, SMBus, EEPROM
// - Sticky and unlock-writable fields survive hot reset
// - Downstream ports send message before own reset
// - Upstream bus reset resets downstream ports only; in bridge mode the code also resets both bridge sides
// - Downstream bus reset: message then phy reset
// - Reset action applied on opposite side reset
// - Internal fundamental reset marks far side unready
// - Propagated external reset becomes full fundamental reset
// - Plain external reset resets external side only
// - External reset performs enabled reset action
// - External reset sets internal far-reset flag, interrupt
// - External reset sets internal fundamental-reset flag
// - External reset pulses port C output if selected
// - Global hot reset returns GPIO to input
// - Internal side hot reset trigger list
// - Internal hot reset resets both bridge sides
// - External action fields read zero during reset
// - Internal hot reset sets external far-reset flag
// - Internal hot reset sets sticky external hot flag
// - Internal hot reset drives port C low 250ns
// - Downstream hot reset pulses port reset output
module hot_reset_ctrl
	import hot_reset_pkg::*;
#(
	parameter int unsigned PULSE_CYCLES = `RST_PULSE_CYCLES,
	parameter int unsigned MSG_CYCLES = `HOT_MSG_CYCLES
) (
	// Clock and reset (fundamental reset of the device)
	input wire logic core_clk_in,
	input wire logic reset_in,
	// Link events
	input wire logic up_hot_ts_in,
	input wire logic up_dl_down_in,
	input wire logic dn_hot_ts_in,
	// Register write strobes
	input wire logic up_secondary_bus_reset_bit_in,
	input wire logic b_secondary_bus_reset_bit_in,
	input wire logic c_secondary_bus_reset_bit_in,
	input wire logic c_bridge_reset_wr_in,
	// Mode and configuration
	input wire logic nonxp_mode_in,
	input wire logic int_propagate_ext_fund_reset_in,
	input wire logic ext_propagate_ext_fund_reset_in,
	input wire logic int_reset_action_enable_in,
	input wire logic [1:0] int_reset_action_code_in,
	input wire logic ext_reset_action_enable_in,
	input wire logic [1:0] ext_reset_action_code_in,
	input wire logic [1:0] reset_out_select_in,
	input wire logic int_far_reset_int_en_in,
	input wire logic [1:0] int_far_mode_wr_in,
	input wire logic int_far_mode_we_in,
	input wire logic ext_side_reset_n_in,
	// Status clears (write one to clear)
	input wire logic int_status_clr_in,
	input wire logic ext_status_clr_in,
	// Reset domains
	output logic device_hot_reset_out,
	output logic int_side_reset_out,
	output logic ext_side_reset_out,
	output logic fund_reset_req_out,
	output logic nonsticky_reset_out,
	output logic gpio_to_input_out,
	// Downstream ports
	output logic port_b_hot_msg_out,
	output logic port_c_hot_msg_out,
	output logic port_b_phy_reset_out,
	output logic port_c_phy_reset_out,
	output logic port_b_reset_out_n,
	output logic port_c_reset_out_n,
	// Bridge status
	output logic [1:0] int_far_side_mode_out,
	output logic int_side_not_ready_out,
	output logic ext_side_not_ready_out,
	output logic int_far_side_reset_seen_out,
	output logic int_far_side_fund_reset_seen_out,
	output logic ext_far_side_reset_seen_out,
	output logic ext_far_side_hot_reset_seen_out,
	output logic int_irq_out,
	output logic ext_reset_action_enable_out,
	output logic [1:0] ext_reset_action_code_out
);
	////////////////////////////////////////////////////////////////////////////
	// Event decode
	logic ext_rst_q_r, ext_rst_q_nxt;
	logic ext_fall, global_hot, int_hot, dn_hot, ext_fund, prop_fund;
	logic b_start, c_start;

	// Falling edge of the external bridge reset pin, only in bridge mode
	assign ext_fall = ext_rst_q_r & ~ext_side_reset_n_in & nonxp_mode_in;
	assign global_hot = up_hot_ts_in | up_dl_down_in;
	// Downstream hot-reset sets never enter any trigger term
	assign dn_hot = up_secondary_bus_reset_bit_in;
	assign int_hot = nonxp_mode_in & (global_hot | c_bridge_reset_wr_in | up_secondary_bus_reset_bit_in);
	assign prop_fund = ext_fall & (int_propagate_ext_fund_reset_in | ext_propagate_ext_fund_reset_in);
	assign ext_fund = ext_fall & ~prop_fund;
	assign b_start = global_hot | dn_hot | b_secondary_bus_reset_bit_in;
	assign c_start = (global_hot | dn_hot | c_secondary_bus_reset_bit_in) & ~nonxp_mode_in;

	////////////////////////////////////////////////////////////////////////////
	// Downstream sequencers and pulse timers
	logic b_msg, c_msg, b_rst, c_rst, b_pn, c_pn, c_fire;

	downstream_hot_seq #(.MSG_CYCLES(MSG_CYCLES)) u_seq_b (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.start_in(b_start),
		.send_msg_out(b_msg),
		.port_reset_out(b_rst)
	);
	downstream_hot_seq #(.MSG_CYCLES(MSG_CYCLES)) u_seq_c (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.start_in(c_start),
		.send_msg_out(c_msg),
		.port_reset_out(c_rst)
	);

	// Port C pulse also fires for bridge-side resets
	assign c_fire = c_rst | int_hot | (ext_fund & (reset_out_select_in == `ROS_EXT_RESET));

	// Port B pulse follows its own phy reset only
	reset_pulse_gen #(.CYCLES(PULSE_CYCLES)) u_pulse_b (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.fire_in(b_rst),
		.pulse_n_out(b_pn)
	);
	reset_pulse_gen #(.CYCLES(PULSE_CYCLES)) u_pulse_c (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.fire_in(c_fire),
		.pulse_n_out(c_pn)
	);

	////////////////////////////////////////////////////////////////////////////
	// Bridge state and flags
	logic [1:0] far_mode_r, far_mode_nxt;
	logic int_nr_r, int_nr_nxt, ext_nr_r, ext_nr_nxt;
	logic i_far_seen_r, i_far_seen_nxt, i_far_fund_r, i_far_fund_nxt;
	logic e_far_seen_r, e_far_seen_nxt, e_far_hot_r, e_far_hot_nxt;
	logic irq_r, irq_nxt;

	// Apply a reset action code to the not-ready pair
	function automatic logic [1:0] apply_action(input logic [1:0] code, input logic [1:0] cur);
		apply_action = cur;
		if (code == `ACTION_INT_NOT_READY) apply_action[0] = 1'b1;
		if (code == `ACTION_EXT_NOT_READY) apply_action[1] = 1'b1;
	endfunction

	// Sets win over clears so no reset event is lost
	always_comb begin
		logic [1:0] nr;
		nr = {ext_nr_r, int_nr_r};
		ext_rst_q_nxt = ext_side_reset_n_in;
		far_mode_nxt = int_far_mode_we_in ? int_far_mode_wr_in : far_mode_r;
		if (ext_fund && int_reset_action_enable_in) nr = apply_action(int_reset_action_code_in, nr);
		// External action fields read zero during an internal hot reset, so they never act on it
		int_nr_nxt = nr[0];
		ext_nr_nxt = nr[1];
		i_far_seen_nxt = ext_fund | (i_far_seen_r & ~int_status_clr_in);
		i_far_fund_nxt = ext_fund | (i_far_fund_r & ~int_status_clr_in);
		e_far_seen_nxt = int_hot | (e_far_seen_r & ~ext_status_clr_in);
		e_far_hot_nxt = int_hot | (e_far_hot_r & ~ext_status_clr_in);
		irq_nxt = i_far_seen_nxt & int_far_reset_int_en_in;
	end

	// Fundamental reset forces far side not ready; of the hot resets only an internal one sets flags, the external far-reset pair
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			ext_rst_q_r <= 1'b1;
			far_mode_r <= `FAR_MODE_NOT_READY;
			int_nr_r <= 1'b0;
			ext_nr_r <= 1'b0;
			i_far_seen_r <= 1'b0;
			i_far_fund_r <= 1'b0;
			e_far_seen_r <= 1'b0;
			e_far_hot_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			ext_rst_q_r <= ext_rst_q_nxt;
			far_mode_r <= far_mode_nxt;
			int_nr_r <= int_nr_nxt;
			ext_nr_r <= ext_nr_nxt;
			i_far_seen_r <= i_far_seen_nxt;
			i_far_fund_r <= i_far_fund_nxt;
			e_far_seen_r <= e_far_seen_nxt;
			e_far_hot_r <= e_far_hot_nxt;
			irq_r <= irq_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registered reset domain outputs
	logic dev_r, int_r, ext_r, fund_r, nst_r, gpio_r;
	logic bm_r, cm_r, bp_r, cp_r, bn_r, cn_r, era_en_r;
	logic [1:0] era_code_r;
	logic dev_nxt, int_nxt, ext_nxt, fund_nxt, nst_nxt, gpio_nxt, era_en_nxt;
	logic [1:0] era_code_nxt;

	// Global reset hits bridges, stacks and core; PLL, SerDes, SMBus and EEPROM are outside
	always_comb begin
		dev_nxt = global_hot;
		int_nxt = int_hot;
		ext_nxt = int_hot | ext_fund;
		fund_nxt = prop_fund;
		nst_nxt = global_hot | dn_hot | int_hot | ext_fund;
		gpio_nxt = global_hot;
		era_en_nxt = int_hot ? 1'b0 : ext_reset_action_enable_in;
		era_code_nxt = int_hot ? 2'h0 : ext_reset_action_code_in;
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			dev_r <= 1'b0;
			int_r <= 1'b0;
			ext_r <= 1'b0;
			fund_r <= 1'b0;
			nst_r <= 1'b0;
			gpio_r <= 1'b1;
			bm_r <= 1'b0;
			cm_r <= 1'b0;
			bp_r <= 1'b0;
			cp_r <= 1'b0;
			bn_r <= 1'b1;
			cn_r <= 1'b1;
			era_en_r <= 1'b0;
			era_code_r <= 2'h0;
		end else begin
			dev_r <= dev_nxt;
			int_r <= int_nxt;
			ext_r <= ext_nxt;
			fund_r <= fund_nxt;
			nst_r <= nst_nxt;
			gpio_r <= gpio_nxt;
			bm_r <= b_msg;
			cm_r <= c_msg;
			bp_r <= b_rst;
			cp_r <= c_rst;
			bn_r <= b_pn;
			cn_r <= c_pn;
			era_en_r <= era_en_nxt;
			era_code_r <= era_code_nxt;
		end
	end

	assign device_hot_reset_out = dev_r;
	assign int_side_reset_out = int_r;
	assign ext_side_reset_out = ext_r;
	assign fund_reset_req_out = fund_r;
	assign nonsticky_reset_out = nst_r;
	assign gpio_to_input_out = gpio_r;
	assign port_b_hot_msg_out = bm_r;
	assign port_c_hot_msg_out = cm_r;
	assign port_b_phy_reset_out = bp_r;
	assign port_c_phy_reset_out = cp_r;
	assign port_b_reset_out_n = bn_r;
	assign port_c_reset_out_n = cn_r;
	assign int_far_side_mode_out = far_mode_r;
	assign int_side_not_ready_out = int_nr_r;
	assign ext_side_not_ready_out = ext_nr_r;
	assign int_far_side_reset_seen_out = i_far_seen_r;
	assign int_far_side_fund_reset_seen_out = i_far_fund_r;
	assign ext_far_side_reset_seen_out = e_far_seen_r;
	assign ext_far_side_hot_reset_seen_out = e_far_hot_r;
	assign int_irq_out = irq_r;
	assign ext_reset_action_enable_out = era_en_r;
	assign ext_reset_action_code_out = era_code_r;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_up_hot_dev: assert property (@(posedge core_clk_in) disable iff (reset_in)
		global_hot |=> device_hot_reset_out)
		else $error("upstream hot reset not taken");
	// Antecedent uses the raw pins, so a downstream set wired into any nonsticky reset term is caught
	a_dn_ts_ignored: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(dn_hot_ts_in && !up_hot_ts_in && !up_dl_down_in && !up_secondary_bus_reset_bit_in
			&& !c_bridge_reset_wr_in && !ext_fall) |=> !nonsticky_reset_out)
		else $error("downstream sets caused reset");
	a_ext_flag_set: assert property (@(posedge core_clk_in) disable iff (reset_in)
		ext_fund |=> (int_far_side_reset_seen_out && int_far_side_fund_reset_seen_out))
		else $error("external reset flags missing");
	a_int_hot_flags: assert property (@(posedge core_clk_in) disable iff (reset_in)
		int_hot |=> (ext_far_side_reset_seen_out && ext_far_side_hot_reset_seen_out && int_side_reset_out))
		else $error("internal hot flags missing");
	a_prop_fund: assert property (@(posedge core_clk_in) disable iff (reset_in)
		prop_fund |=> (fund_reset_req_out && !ext_side_reset_out))
		else $error("propagated reset not full");
	a_era_zero: assert property (@(posedge core_clk_in) disable iff (reset_in)
		int_hot |=> (!ext_reset_action_enable_out && ext_reset_action_code_out == 2'h0))
		else $error("action fields not zero");
	a_c_pulse: assert property (@(posedge core_clk_in) disable iff (reset_in)
		int_hot |=> ##[1:3] !port_c_reset_out_n)
		else $error("port C pulse missing");
	a_port_b_pulse: assert property (@(posedge core_clk_in) disable iff (reset_in)
		port_b_phy_reset_out |=> !port_b_reset_out_n)
		else $error("port B pulse missing");
	a_gpio_input: assert property (@(posedge core_clk_in) disable iff (reset_in)
		global_hot |=> gpio_to_input_out)
		else $error("GPIO not returned to input");
endmodule // hot_reset_ctrl

// ==== sim/link_partner_model.sv ====
// Link partner model: upstream and downstream link events, hot-reset message counts
module link_partner_model (
	// Clock
	input wire logic core_clk_in,
	// Link events toward the switch
	output logic up_hot_ts_out,
	output logic up_dl_down_out,
	output logic dn_hot_ts_out,
	// Hot-reset messages seen on the downstream links
	input wire logic port_b_hot_msg_in,
	input wire logic port_c_hot_msg_in,
	output logic [7:0] msg_b_cnt_out,
	output logic [7:0] msg_c_cnt_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic msg_b_d = 1'h0;
	logic msg_c_d = 1'h0;
	initial begin
		{up_hot_ts_out, up_dl_down_out, dn_hot_ts_out} = 3'h0;
		msg_b_cnt_out = 8'h00;
		msg_c_cnt_out = 8'h00;
	end
	////////////////////////////////////////////////////////////////////////////////
	// One-cycle event off the falling edge; delay models a slow partner
	task automatic send(input int kind, input int delay);
		repeat (delay) @(negedge core_clk_in);
		{up_hot_ts_out, up_dl_down_out, dn_hot_ts_out} = 3'h4 >> kind;
		@(negedge core_clk_in);
		{up_hot_ts_out, up_dl_down_out, dn_hot_ts_out} = 3'h0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// A fresh message restarts the count, so a stale one is never credited
	always @(posedge core_clk_in) begin
		msg_b_d <= port_b_hot_msg_in;
		msg_c_d <= port_c_hot_msg_in;
		if (port_b_hot_msg_in) begin
			msg_b_cnt_out <= msg_b_d ? msg_b_cnt_out + 8'h01 : 8'h01;
		end
		if (port_c_hot_msg_in) begin
			msg_c_cnt_out <= msg_c_d ? msg_c_cnt_out + 8'h01 : 8'h01;
		end
	end
endmodule // link_partner_model

// ==== sim/testbench.sv ====
// Self-checking bench for the hot and bridge-side reset control block
`include "hot_reset_defines.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MSG = 2;
	localparam int PULSE = `RST_PULSE_CYCLES;
	logic core_clk_in = 1'h0;
	logic reset_in = 1'h1;
	logic up_secondary_bus_reset_bit_in = 1'h0, b_secondary_bus_reset_bit_in = 1'h0;
	logic c_secondary_bus_reset_bit_in = 1'h0, c_bridge_reset_wr_in = 1'h0, nonxp_mode_in = 1'h0;
	logic int_propagate_ext_fund_reset_in = 1'h0, ext_propagate_ext_fund_reset_in = 1'h0;
	logic int_reset_action_enable_in = 1'h0, ext_reset_action_enable_in = 1'h0;
	logic int_far_reset_int_en_in = 1'h0, int_far_mode_we_in = 1'h0, ext_side_reset_n_in = 1'h1;
	logic int_status_clr_in = 1'h0, ext_status_clr_in = 1'h0;
	logic [1:0] int_reset_action_code_in = 2'h0, ext_reset_action_code_in = 2'h0;
	logic [1:0] reset_out_select_in = 2'h0, int_far_mode_wr_in = 2'h0;
	logic up_hot_ts_in, up_dl_down_in, dn_hot_ts_in;
	logic device_hot_reset_out, int_side_reset_out, ext_side_reset_out, fund_reset_req_out;
	logic nonsticky_reset_out, gpio_to_input_out, port_b_hot_msg_out, port_c_hot_msg_out;
	logic port_b_phy_reset_out, port_c_phy_reset_out, port_b_reset_out_n, port_c_reset_out_n;
	logic int_side_not_ready_out, ext_side_not_ready_out, int_far_side_reset_seen_out, int_irq_out;
	logic int_far_side_fund_reset_seen_out, ext_far_side_reset_seen_out, ext_far_side_hot_reset_seen_out;
	logic ext_reset_action_enable_out;
	logic [1:0] int_far_side_mode_out, ext_reset_action_code_out;
	logic [7:0] msg_b_cnt, msg_c_cnt;
	logic [7:0] lfsr = 8'h3b;
	logic [1:0] q_ev[$];
	int q_wb[$], q_wc[$];
	int failures = 0, n_checks = 0, cycles = 0, wb = 0, wc = 0;

	always #5 core_clk_in = ~core_clk_in;

	hot_reset_ctrl #(.PULSE_CYCLES(PULSE), .MSG_CYCLES(MSG)) i_hot_reset_ctrl (.core_clk_in, .reset_in,
		.up_hot_ts_in, .up_dl_down_in, .dn_hot_ts_in, .up_secondary_bus_reset_bit_in,
		.b_secondary_bus_reset_bit_in, .c_secondary_bus_reset_bit_in, .c_bridge_reset_wr_in, .nonxp_mode_in,
		.int_propagate_ext_fund_reset_in, .ext_propagate_ext_fund_reset_in, .int_reset_action_enable_in,
		.int_reset_action_code_in, .ext_reset_action_enable_in, .ext_reset_action_code_in, .reset_out_select_in,
		.int_far_reset_int_en_in, .int_far_mode_wr_in, .int_far_mode_we_in, .ext_side_reset_n_in,
		.int_status_clr_in, .ext_status_clr_in, .device_hot_reset_out, .int_side_reset_out, .ext_side_reset_out,
		.fund_reset_req_out, .nonsticky_reset_out, .gpio_to_input_out, .port_b_hot_msg_out, .port_c_hot_msg_out,
		.port_b_phy_reset_out, .port_c_phy_reset_out, .port_b_reset_out_n, .port_c_reset_out_n,
		.int_far_side_mode_out, .int_side_not_ready_out, .ext_side_not_ready_out, .int_far_side_reset_seen_out,
		.int_far_side_fund_reset_seen_out, .ext_far_side_reset_seen_out, .ext_far_side_hot_reset_seen_out,
		.int_irq_out, .ext_reset_action_enable_out, .ext_reset_action_code_out);

	link_partner_model i_link_partner_model (.core_clk_in, .up_hot_ts_out(up_hot_ts_in),
		.up_dl_down_out(up_dl_down_in), .dn_hot_ts_out(dn_hot_ts_in), .port_b_hot_msg_in(port_b_hot_msg_out),
		.port_c_hot_msg_in(port_c_hot_msg_out), .msg_b_cnt_out(msg_b_cnt), .msg_c_cnt_out(msg_c_cnt));

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [7:0] next_rand();
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		return lfsr;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Strobe held one full cycle; outputs have landed when it returns
	task automatic strobe(ref logic s);
		s = 1'h1;
		@(negedge core_clk_in);
		s = 1'h0;
	endtask
	task automatic ext_pin_fall();
		ext_side_reset_n_in = 1'h0;
		repeat (3) @(negedge core_clk_in);
		ext_side_reset_n_in = 1'h1;
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Monitor: each result takes the oldest note; a result with no note is a mismatch
	always @(negedge core_clk_in) begin
		if (device_hot_reset_out | fund_reset_req_out) begin
			check({device_hot_reset_out, fund_reset_req_out}, q_ev.size() ? q_ev.pop_front() : 2'h0);
		end
		if (!port_b_reset_out_n) begin
			wb++;
		end else if (wb != 0) begin
			check(wb, q_wb.size() ? q_wb.pop_front() : 0);
			wb = 0;
		end
		if (!port_c_reset_out_n) begin
			wc++;
		end else if (wc != 0) begin
			check(wc, q_wc.size() ? q_wc.pop_front() : 0);
			wc = 0;
		end
		if (port_b_phy_reset_out) check(msg_b_cnt, MSG);
		if (port_c_phy_reset_out) check(msg_c_cnt, MSG);
		cycles++;
		if (cycles > 5000) begin
			failures++;
			close_out();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (6) @(negedge core_clk_in);
		check(int_far_side_mode_out, `FAR_MODE_NOT_READY);
		reset_in = 1'h0;
		// Both upstream link events reset the device and both downstream ports
		for (int k = 0; k < 2; k++) begin
			q_ev.push_back(2'h2);
			q_wb.push_back(PULSE);
			q_wc.push_back(PULSE);
			i_link_partner_model.send(k, next_rand() % 4);
			check({gpio_to_input_out, nonsticky_reset_out}, 2'h3);
			repeat (40) @(negedge core_clk_in);
		end
		// Downstream hot-reset sets must be ignored
		i_link_partner_model.send(2, 0);
		check({port_b_hot_msg_out, gpio_to_input_out, nonsticky_reset_out, port_b_reset_out_n}, 4'h1);
		repeat (40) @(negedge core_clk_in);
		$display("test upstream and downstream link events done");
		// Local resets back to back, then the upstream bus reset
		q_wb.push_back(PULSE);
		q_wc.push_back(PULSE);
		strobe(b_secondary_bus_reset_bit_in);
		strobe(c_secondary_bus_reset_bit_in);
		repeat (40) @(negedge core_clk_in);
		q_wb.push_back(PULSE);
		q_wc.push_back(PULSE);
		strobe(up_secondary_bus_reset_bit_in);
		repeat (40) @(negedge core_clk_in);
		$display("test bus reset bits done");
		// External pin outside bridge mode must do nothing
		int_propagate_ext_fund_reset_in = 1'h1;
		ext_pin_fall();
		check(int_far_side_reset_seen_out, 1'h0);
		int_propagate_ext_fund_reset_in = 1'h0;
		// Bridge mode: software marks far side ready, then external reset
		nonxp_mode_in = 1'h1;
		int_reset_action_enable_in = 1'h1;
		int_reset_action_code_in = `ACTION_INT_NOT_READY;
		int_far_reset_int_en_in = 1'h1;
		reset_out_select_in = `ROS_EXT_RESET;
		int_far_mode_wr_in = `FAR_MODE_READY;
		strobe(int_far_mode_we_in);
		check(int_far_side_mode_out, `FAR_MODE_READY);
		q_wc.push_back(PULSE);
		ext_pin_fall();
		check({int_far_side_reset_seen_out, int_irq_out}, 2'h3);
		check({int_far_side_fund_reset_seen_out, int_side_not_ready_out}, 2'h3);
		strobe(int_status_clr_in);
		check({int_far_side_reset_seen_out, int_far_side_fund_reset_seen_out, int_irq_out}, 3'h0);
		repeat (30) @(negedge core_clk_in);
		// Output not selected: flags rise, port C stays quiet; action now marks the external side
		reset_out_select_in = 2'h0;
		int_reset_action_code_in = `ACTION_EXT_NOT_READY;
		ext_pin_fall();
		check({int_far_side_fund_reset_seen_out, ext_side_not_ready_out}, 2'h3);
		repeat (30) @(negedge core_clk_in);
		// Propagation turns the external reset into a full fundamental reset
		ext_propagate_ext_fund_reset_in = 1'h1;
		q_ev.push_back(2'h1);
		ext_pin_fall();
		ext_propagate_ext_fund_reset_in = 1'h0;
		repeat (10) @(negedge core_clk_in);
		$display("test external fundamental reset done");
		// Internal side hot reset from the port C bit and the upstream bus reset bit
		ext_reset_action_enable_in = 1'h1;
		for (int k = 0; k < 2; k++) begin
			ext_reset_action_code_in = next_rand() % 4;
			q_wc.push_back(PULSE);
			if (k == 1) q_wb.push_back(PULSE);
			if (k == 0) strobe(c_bridge_reset_wr_in);
			else strobe(up_secondary_bus_reset_bit_in);
			check({int_side_reset_out, ext_side_reset_out, ext_reset_action_enable_out,
				ext_reset_action_code_out}, 5'h18);
			check({ext_far_side_reset_seen_out, ext_far_side_hot_reset_seen_out}, 2'h3);
			repeat (40) @(negedge core_clk_in);
			check({ext_far_side_reset_seen_out, ext_far_side_hot_reset_seen_out}, 2'h3);
			check({ext_reset_action_enable_out, ext_reset_action_code_out}, {1'h1, ext_reset_action_code_in});
			strobe(ext_status_clr_in);
			check({ext_far_side_reset_seen_out, ext_far_side_hot_reset_seen_out}, 2'h0);
		end
		$display("test internal side hot reset done");
		check(q_ev.size() + q_wb.size() + q_wc.size(), 0);
		close_out();
	end
endmodule // testbench
